// File: common/ssm_params.svh
// Constants of the safety stop monitor: offsets, codes, fields, timing.
// Notes on behaviour
// - Any open channel stops; both shorted releases
// - Stop status on when shut off, healthy
// - Stop status off when driving or faulted
// - Health output follows absence of any fault
// - Codes 80/180 route stop status, polarity
// - Codes 81/181 route health signal, polarity
// - Run pin: running by default, 81 health
// - Run pin health drops within two cycles of fault
// - Fault shows circuit or processor fault code
// - Both open, no fault: dual-open notice
`ifndef SSM_PARAMS_SVH
`define SSM_PARAMS_SVH
`define SSM_ADDR_W          8
`define SSM_DATA_W          32
`define SSM_PRM_W           8
`define SSM_OFS_RUN_ASSIGN  8'h00
`define SSM_OFS_SEC_ASSIGN  8'h04
`define SSM_OFS_THD_ASSIGN  8'h08
`define SSM_OFS_STATUS      8'h0C
`define SSM_OFS_INT_STAT    8'h10
`define SSM_OFS_INT_MASK    8'h14
`define SSM_FN_RUNNING      8'h00
`define SSM_FN_STOP_POS     8'h50
`define SSM_FN_STOP_NEG     8'hB4
`define SSM_FN_HEALTH_POS   8'h51
`define SSM_FN_HEALTH_NEG   8'hB5
`define SSM_RST_RUN_ASSIGN  8'h00
`define SSM_RST_SEC_ASSIGN  8'h00
`define SSM_RST_THD_ASSIGN  8'h00
`define SSM_INT_W           4
`define SSM_INT_STOP        0
`define SSM_INT_DRIVE       1
`define SSM_INT_FAULT       2
`define SSM_INT_MISMATCH    3
`define SSM_RST_INT_MASK    4'h0
`define SSM_CLK_MHZ         125
`define SSM_DEBOUNCE_US     1000
`define SSM_DEBOUNCE_CYC    (`SSM_DEBOUNCE_US * `SSM_CLK_MHZ)
`endif

// File: common/ssm_pkg.sv
// Types shared by the safety stop monitor files.
package ssm_pkg;
  // Safety state of the drive stage
  typedef enum logic [1:0] {
    SSM_ST_STOP  = 2'b00,  // Safe stop, output shut off
    SSM_ST_RUN   = 2'b01,  // Drive enabled
    SSM_ST_FAULT = 2'b10   // Shut off by circuit, processor or channel fault
  } ssm_state_t;
  // Operator display code
  typedef enum logic [1:0] {
    SSM_DISP_NONE   = 2'b00,  // Nothing to report
    SSM_DISP_DUAL   = 2'b01,  // Dual-open notice
    SSM_DISP_CIRC   = 2'b10,  // Safety circuit fault code
    SSM_DISP_CPU    = 2'b11   // Processor fault code
  } ssm_disp_t;
  // Status bundle as read by software
  typedef struct packed {
    ssm_disp_t  disp;        // Display code
    ssm_state_t state;       // Safety state
    logic       health;      // Health flag
    logic       stop;        // Stop-monitor status
    logic       drive;       // Drive enable
    logic       chan_a;      // Debounced channel A shorted
    logic       chan_b;      // Debounced channel B shorted
    logic       circ_fault;  // Latched circuit fault
    logic       cpu_fault;   // Latched processor fault
  } ssm_status_t;
endpackage : ssm_pkg

// File: dv/ssm_relay_model.sv
// Model of the external safety relay module that drives both channels.
`timescale 1ns/100ps
`default_nettype none
module ssm_relay_model (
  input  wire logic clk_in,      // System clock
  input  wire logic rst_in,      // Sync reset, high
  input  wire logic close_in,    // Request to close the channels
  input  wire logic split_in,    // Open channel B alone
  input  wire logic feedback_in, // Health fed back from the run terminal
  output logic      chan_a_out,  // Channel A, 1 = shorted
  output logic      chan_b_out   // Channel B, 1 = shorted
);
  logic lock_ff;  // Restart blocked once feedback dropped

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lock_ff <= 1'b0;
    end else if (close_in && !split_in && !feedback_in) begin
      // Only a healthy device may be released again
      lock_ff <= 1'b1;
    end
  end

  assign chan_a_out = close_in && !lock_ff;
  assign chan_b_out = close_in && !lock_ff && !split_in;
endmodule : ssm_relay_model
`default_nettype wire

// File: dv/ssm_top_tb.sv
// Self-checking bench for the safety stop monitor.
`timescale 1ns/100ps
`default_nettype none
`include "ssm_params.svh"
module ssm_top_tb;
  localparam int DEB = 4;           // Short debounce keeps the run brief
  logic        clk_in      = 1'b0;  // Bench clock
  logic        rst_in      = 1'b1;  // Sync reset
  logic        cpu_flt     = 1'b0;  // Processor fault
  logic        circ_flt    = 1'b0;  // Circuit fault pulse
  logic        running     = 1'b0;  // Running indication
  logic        close_req   = 1'b0;  // Relay close request
  logic        split_req   = 1'b0;  // Relay opens channel B alone
  logic [7:0]  addr        = 8'h00; // Bus address
  logic [31:0] wdata       = 32'h0; // Bus write data
  logic        wr          = 1'b0;  // Write strobe
  logic        rd          = 1'b0;  // Read strobe
  logic        ce          = 1'b1;  // Clock enable
  logic [31:0] rdata;               // Bus read data
  logic        drive, mon, health;  // Safety outputs
  logic        run_pin, sec_pin, thd_pin, irq, ch_a, ch_b; // Terminals, channels
  ssm_pkg::ssm_disp_t disp;         // Display code
  integer      seed        = 32'hf919; // Fixed seed
  int          bad_count   = 0;     // Mismatches
  int          comparisons = 0;     // Checks made
  int          cycles      = 0;     // Hang guard
  logic [7:0]  codes [5] = '{`SSM_FN_STOP_POS, `SSM_FN_STOP_NEG, `SSM_FN_HEALTH_POS,
                             `SSM_FN_HEALTH_NEG, `SSM_FN_RUNNING}; // Assignment codes
  logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18}; // Zero after reset

  ssm_top #(.DEBOUNCE_CYCLES(DEB)) u_ssm_top (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .channel_a_input(ch_a),
    .channel_b_input(ch_b), .circ_fault_in(circ_flt), .cpu_fault_in(cpu_flt),
    .running_in(running), .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
    .rd_data_out(rdata), .drive_enable_out(drive), .monitor_pin_out(mon),
    .circuit_health_flag(health), .run_pin_out(run_pin), .second_pin_out(sec_pin),
    .third_pin_out(thd_pin), .display_code_out(disp), .irq_out(irq));
  ssm_relay_model u_ssm_relay_model (.clk_in(clk_in), .rst_in(rst_in), .close_in(close_req),
    .split_in(split_req), .feedback_in(run_pin), .chan_a_out(ch_a), .chan_b_out(ch_b));

  // Clock and hang guard
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // Expected terminal level for one code
  function automatic logic pin_exp(input logic [7:0] c, input logic s, h, r);
    case (c)
      `SSM_FN_RUNNING:    pin_exp = r;
      `SSM_FN_STOP_POS:   pin_exp = s;
      `SSM_FN_STOP_NEG:   pin_exp = !s;
      `SSM_FN_HEALTH_POS: pin_exp = h;
      `SSM_FN_HEALTH_NEG: pin_exp = !h;
      default:            pin_exp = 1'b0;
    endcase
  endfunction : pin_exp

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk("read", exp, rdata);
    @(posedge clk_in);
    #1;
    chk("read idle", 32'h0, rdata);
  endtask : rd_reg

  task automatic st(input logic d, s, h, input logic [1:0] c);
    chk("drive", {31'h0, d}, {31'h0, drive});
    chk("monitor", {31'h0, s}, {31'h0, mon});
    chk("health", {31'h0, h}, {31'h0, health});
    chk("display", {30'h0, c}, {30'h0, disp});
  endtask : st

  // Every code on both spare terminals, random running level
  task automatic pins(input logic s, h);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      running <= 1'($random(seed));
      wr_reg(`SSM_OFS_SEC_ASSIGN, {24'h0, codes[i]});
      wr_reg(`SSM_OFS_THD_ASSIGN, {24'h0, codes[4 - i]});
      tick(3);
      chk("second", {31'h0, pin_exp(codes[i], s, h, running)}, {31'h0, sec_pin});
      chk("third", {31'h0, pin_exp(codes[4 - i], s, h, running)}, {31'h0, thd_pin});
      chk("run", {31'h0, h}, {31'h0, run_pin});
    end
  endtask : pins

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    tick(12);
    rst_in <= 1'b0;
    wr_reg(8'h18, $random(seed));
    for (int i = 0; i < 5; i++) rd_reg(offs[i], 32'h0);
    tick(10);
    st(1'b0, 1'b1, 1'b1, 2'b01);
    wr_reg(`SSM_OFS_RUN_ASSIGN, {24'h0, `SSM_FN_HEALTH_POS});
    pins(1'b1, 1'b1);
    $display("test stop done");
    wr_reg(`SSM_OFS_INT_STAT, 32'hF);
    wr_reg(`SSM_OFS_INT_MASK, 32'h2);
    close_req <= 1'b1;
    tick(3);
    chk("early drive", 32'h0, {31'h0, drive});
    tick(8);
    st(1'b1, 1'b0, 1'b1, 2'b00);
    chk("irq set", 32'h1, {31'h0, irq});
    wr_reg(`SSM_OFS_INT_STAT, 32'h2);
    tick(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd_reg(`SSM_OFS_RUN_ASSIGN, {24'h0, `SSM_FN_HEALTH_POS});
    rd_reg(`SSM_OFS_STATUS, 32'h000000DC);
    pins(1'b0, 1'b1);
    $display("test run done");
    ce <= 1'b0;
    split_req <= 1'b1;
    tick(12);
    st(1'b1, 1'b0, 1'b1, 2'b00); // Frozen by clock enable
    ce <= 1'b1;
    tick(10);
    st(1'b0, 1'b0, 1'b0, 2'b10);
    close_req <= 1'b0;
    split_req <= 1'b0;
    tick(10);
    st(1'b0, 1'b1, 1'b1, 2'b01);
    $display("test mismatch done");
    close_req <= 1'b1;
    tick(10);
    @(posedge clk_in);
    cpu_flt <= 1'b1;
    @(posedge clk_in);
    cpu_flt <= 1'b0;
    tick(2);
    chk("fault run pin", 32'h0, {31'h0, run_pin});
    tick(10);
    st(1'b0, 1'b0, 1'b0, 2'b11);
    chk("relay lock", 32'h0, {31'h0, ch_a});
    rd_reg(`SSM_OFS_INT_STAT, 32'h0000000F);
    close_req <= 1'b0;
    rst_in <= 1'b1;
    tick(2);
    rst_in <= 1'b0;
    tick(2);
    circ_flt <= 1'b1;
    tick(1);
    circ_flt <= 1'b0;
    tick(10);
    st(1'b0, 1'b0, 1'b0, 2'b10);
    $display("test fault done");
    tally_and_finish();
  end
endmodule : ssm_top_tb
`default_nettype wire

// File: hdl/ssm_debounce.sv
// Two-stage synchroniser and stability filter for one channel pin.
`timescale 1ns/100ps
`default_nettype none
module ssm_debounce #(
  parameter int CYCLES = 125000  // Cycles a level must hold
) (
  input  wire logic clk_in,     // System clock
  input  wire logic rst_in,     // Synchronous reset
  input  wire logic ce_in,      // Clock enable
  input  wire logic pin_in,     // Raw pin, other domain
  output logic      stable_out  // Filtered level
);
  localparam int CW = $clog2(CYCLES + 1);
  if (CYCLES < 1) begin : g_bad_cycles
    $error("ssm_debounce: CYCLES must be at least one");
  end
  logic          meta_ff;   // First stage, read only by sync_ff
  logic          sync_ff;   // Second stage
  logic [CW-1:0] cnt_ff;    // Cycles the new level has held
  logic          stable_ff; // Filtered output
  wire           differ = sync_ff != stable_ff;  // New level seen
  wire           done   = cnt_ff == CW'(CYCLES - 1);
  // Reset to open: a stop until proven shorted
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_ff   <= 1'b0;
      sync_ff   <= 1'b0;
      cnt_ff    <= '0;
      stable_ff <= 1'b0;
    end else if (ce_in) begin
      meta_ff   <= pin_in;
      sync_ff   <= meta_ff;
      cnt_ff    <= (differ && !done) ? cnt_ff + CW'(1) : '0;
      stable_ff <= (differ && done) ? sync_ff : stable_ff;
    end
  end
  assign stable_out = stable_ff;
endmodule : ssm_debounce
`default_nettype wire

// File: hdl/ssm_out_route.sv
// One assignable output terminal: function select and polarity.
`timescale 1ns/100ps
`default_nettype none
module ssm_out_route (
  input  wire logic       clk_in,     // System clock
  input  wire logic       rst_in,     // Synchronous reset
  input  wire logic       ce_in,      // Clock enable
  input  wire logic [7:0] prm_in,     // Assignment code
  input  wire logic       stop_in,    // Stop-monitor status
  input  wire logic       health_in,  // Health flag
  input  wire logic       run_in,     // Running indication
  output logic            pin_out     // Terminal level, 1 = on
);
  `include "ssm_params.svh"
  logic pin_ff;  // Registered terminal level
  // Selection of function; unknown codes leave the terminal off
  wire sel_stop_p = prm_in == `SSM_FN_STOP_POS;
  wire sel_stop_n = prm_in == `SSM_FN_STOP_NEG;
  wire sel_hlt_p  = prm_in == `SSM_FN_HEALTH_POS;
  wire sel_hlt_n  = prm_in == `SSM_FN_HEALTH_NEG;
  wire sel_run    = prm_in == `SSM_FN_RUNNING;
  wire nxt_pin    = (sel_stop_p & stop_in) | (sel_stop_n & ~stop_in) |
                    (sel_hlt_p & health_in) | (sel_hlt_n & ~health_in) |
                    (sel_run & run_in);
  // Terminal is off during reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_ff <= 1'b0;
    end else if (ce_in) begin
      pin_ff <= nxt_pin;
    end
  end
  assign pin_out = pin_ff;
endmodule : ssm_out_route

// File: hdl/ssm_top.sv
// Safety stop monitor: channel evaluation, status outputs, registers.
`timescale 1ns/100ps
`default_nettype none
`include "ssm_params.svh"
module ssm_top #(
  // Debounce length; shorten for simulation
  parameter int DEBOUNCE_CYCLES = `SSM_DEBOUNCE_CYC
) (
  input  wire logic                   clk_in,              // 125 MHz clock
  input  wire logic                   rst_in,              // Sync reset, high
  input  wire logic                   ce_in,               // Clock enable
  input  wire logic                   channel_a_input,     // Pin, 1 = shorted
  input  wire logic                   channel_b_input,     // Pin, 1 = shorted
  input  wire logic                   circ_fault_in,       // Circuit fault pulse
  input  wire logic                   cpu_fault_in,        // Processor fault
  input  wire logic                   running_in,          // Drive running
  input  wire logic [`SSM_ADDR_W-1:0] addr_in,             // Register address
  input  wire logic [`SSM_DATA_W-1:0] wr_data_in,          // Write data
  input  wire logic                   wr_in,               // Write strobe
  input  wire logic                   rd_in,               // Read strobe
  output logic      [`SSM_DATA_W-1:0] rd_data_out,         // Read data
  output logic                        drive_enable_out,    // Drive stage on
  output logic                        monitor_pin_out,     // Stop status pin
  output logic                        circuit_health_flag, // Health level
  output logic                        run_pin_out,         // Run terminal
  output logic                        second_pin_out,      // Second terminal
  output logic                        third_pin_out,       // Third terminal
  output ssm_pkg::ssm_disp_t          display_code_out,    // Display code
  output logic                        irq_out              // Level interrupt
);

  // Elaboration check of the debounce length
  if (DEBOUNCE_CYCLES < 1) begin : g_bad_debounce
    $error("ssm_top: DEBOUNCE_CYCLES must be at least one");
  end

  // Debounced channel levels
  logic a_stb;  // Channel A stably shorted
  logic b_stb;  // Channel B stably shorted

  // Register file
  logic [`SSM_PRM_W-1:0] run_assign_ff;  // Run terminal function
  logic [`SSM_PRM_W-1:0] sec_assign_ff;  // Second terminal function
  logic [`SSM_PRM_W-1:0] thd_assign_ff;  // Third terminal function
  logic [`SSM_INT_W-1:0] int_stat_ff;    // Sticky event bits
  logic [`SSM_INT_W-1:0] int_mask_ff;    // Event enables
  logic [`SSM_DATA_W-1:0] rd_data_ff;    // Read answer

  // Safety core state
  ssm_pkg::ssm_state_t state_ff;      // Current safety state
  ssm_pkg::ssm_state_t nxt_state;     // Next safety state
  ssm_pkg::ssm_disp_t  disp_ff;       // Registered display code
  ssm_pkg::ssm_disp_t  nxt_disp;      // Next display code
  logic                circ_flt_ff;   // Latched circuit fault
  logic                cpu_flt_ff;    // Latched processor fault
  logic                drive_ff;      // Registered drive enable
  logic                stop_ff;       // Registered stop status
  logic                health_ff;     // Registered health flag
  ssm_pkg::ssm_status_t status;       // Status bundle for reads

  ssm_debounce #(
    .CYCLES     (DEBOUNCE_CYCLES)
  ) u_deb_a (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .pin_in     (channel_a_input),
    .stable_out (a_stb)
  );

  ssm_debounce #(
    .CYCLES     (DEBOUNCE_CYCLES)
  ) u_deb_b (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .pin_in     (channel_b_input),
    .stable_out (b_stb)
  );

  // Channel decode
  wire both_short = a_stb & b_stb;    // Release condition
  wire both_open  = ~a_stb & ~b_stb;  // Dual-open condition
  // One channel open alone is treated as a circuit discrepancy
  wire mismatch   = a_stb ^ b_stb;

  // Fault inputs act at once, and latch so a restart stays blocked
  wire circ_now  = circ_fault_in | circ_flt_ff;  // Circuit fault present
  wire cpu_now   = cpu_fault_in | cpu_flt_ff;    // Processor fault present
  wire fault_any = circ_now | cpu_now | mismatch;

  // Safety state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // leave stop for run only when both shorted, for fault on any fault
      ssm_pkg::SSM_ST_STOP: begin
        if (fault_any) begin
          nxt_state = ssm_pkg::SSM_ST_FAULT;
        end else if (both_short) begin
          nxt_state = ssm_pkg::SSM_ST_RUN;
        end
      end
      ssm_pkg::SSM_ST_RUN: begin
        if (fault_any) begin
          nxt_state = ssm_pkg::SSM_ST_FAULT;
        end else if (!both_short) begin
          nxt_state = ssm_pkg::SSM_ST_STOP;
        end
      end
      // Latched faults hold here until reset
      ssm_pkg::SSM_ST_FAULT: begin
        if (!fault_any) begin
          nxt_state = ssm_pkg::SSM_ST_STOP;
        end
      end
      default: begin
        nxt_state = ssm_pkg::SSM_ST_FAULT;
      end
    endcase
  end

  // enable only on stable short, no fault
  wire nxt_drive  = both_short & ~fault_any;
  // stop status: shut off and healthy
  wire nxt_stop   = both_open & ~fault_any;
  wire nxt_health = ~fault_any;

  // Display selection; processor fault outranks circuit fault
  always_comb begin
    if (cpu_now) begin
      nxt_disp = ssm_pkg::SSM_DISP_CPU;
    end else if (circ_now | mismatch) begin
      nxt_disp = ssm_pkg::SSM_DISP_CIRC;
    end else if (both_open) begin
      nxt_disp = ssm_pkg::SSM_DISP_DUAL;
    end else begin
      nxt_disp = ssm_pkg::SSM_DISP_NONE;
    end
  end

  // Core registers; reset lands in safe stop with health unproven
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff    <= ssm_pkg::SSM_ST_STOP;
      disp_ff     <= ssm_pkg::SSM_DISP_NONE;
      circ_flt_ff <= 1'b0;
      cpu_flt_ff  <= 1'b0;
      drive_ff    <= 1'b0;
      stop_ff     <= 1'b0;
      health_ff   <= 1'b0;
    end else if (ce_in) begin
      state_ff    <= nxt_state;
      disp_ff     <= nxt_disp;
      circ_flt_ff <= circ_now;
      cpu_flt_ff  <= cpu_now;
      drive_ff    <= nxt_drive;
      stop_ff     <= nxt_stop;
      health_ff   <= nxt_health;
    end
  end

  // with code 81 assigned, health drops the terminal on fault
  ssm_out_route u_route_run (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .prm_in    (run_assign_ff),
    .stop_in   (stop_ff),
    .health_in (health_ff),
    .run_in    (running_in),
    .pin_out   (run_pin_out)
  );

  ssm_out_route u_route_sec (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .prm_in    (sec_assign_ff),
    .stop_in   (stop_ff),
    .health_in (health_ff),
    .run_in    (running_in),
    .pin_out   (second_pin_out)
  );

  ssm_out_route u_route_thd (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .prm_in    (thd_assign_ff),
    .stop_in   (stop_ff),
    .health_in (health_ff),
    .run_in    (running_in),
    .pin_out   (third_pin_out)
  );

  // Events from state changes and channel mismatch, one cycle each
  wire to_stop  = ce_in && nxt_state == ssm_pkg::SSM_ST_STOP
                  && state_ff != ssm_pkg::SSM_ST_STOP;
  wire to_drive = ce_in && nxt_state == ssm_pkg::SSM_ST_RUN
                  && state_ff != ssm_pkg::SSM_ST_RUN;
  wire to_fault = ce_in && nxt_state == ssm_pkg::SSM_ST_FAULT
                  && state_ff != ssm_pkg::SSM_ST_FAULT;
  wire to_mism  = ce_in && mismatch && !(state_ff == ssm_pkg::SSM_ST_FAULT);
  wire [`SSM_INT_W-1:0] ev_set;
  assign ev_set[`SSM_INT_STOP]     = to_stop;
  assign ev_set[`SSM_INT_DRIVE]    = to_drive;
  assign ev_set[`SSM_INT_FAULT]    = to_fault;
  assign ev_set[`SSM_INT_MISMATCH] = to_mism;

  // Address decode
  wire hit_run  = addr_in == `SSM_OFS_RUN_ASSIGN;
  wire hit_sec  = addr_in == `SSM_OFS_SEC_ASSIGN;
  wire hit_thd  = addr_in == `SSM_OFS_THD_ASSIGN;
  wire hit_stat = addr_in == `SSM_OFS_STATUS;
  wire hit_ist  = addr_in == `SSM_OFS_INT_STAT;
  wire hit_imsk = addr_in == `SSM_OFS_INT_MASK;
  wire wr_ok    = wr_in & ce_in;  // Writes are frozen with the block
  wire [`SSM_INT_W-1:0] w1c = (wr_ok & hit_ist) ? wr_data_in[`SSM_INT_W-1:0]
                                                 : '0;

  // Status bundle for software
  assign status.disp       = disp_ff;
  assign status.state      = state_ff;
  assign status.health     = health_ff;
  assign status.stop       = stop_ff;
  assign status.drive      = drive_ff;
  assign status.chan_a     = a_stb;
  assign status.chan_b     = b_stb;
  assign status.circ_fault = circ_flt_ff;
  assign status.cpu_fault  = cpu_flt_ff;

  // Read mux; unmapped addresses answer zero
  wire [`SSM_DATA_W-1:0] rd_mux =
    hit_run  ? {24'h000000, run_assign_ff} :
    hit_sec  ? {24'h000000, sec_assign_ff} :
    hit_thd  ? {24'h000000, thd_assign_ff} :
    hit_stat ? {21'h000000, status} :
    hit_ist  ? {28'h0000000, int_stat_ff} :
    hit_imsk ? {28'h0000000, int_mask_ff} :
               32'h00000000;

  // Software registers; a set in the clearing cycle wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_assign_ff <= `SSM_RST_RUN_ASSIGN;
      sec_assign_ff <= `SSM_RST_SEC_ASSIGN;
      thd_assign_ff <= `SSM_RST_THD_ASSIGN;
      int_stat_ff   <= '0;
      int_mask_ff   <= `SSM_RST_INT_MASK;
    end else begin
      if (wr_ok && hit_run) begin
        run_assign_ff <= wr_data_in[`SSM_PRM_W-1:0];
      end
      if (wr_ok && hit_sec) begin
        sec_assign_ff <= wr_data_in[`SSM_PRM_W-1:0];
      end
      if (wr_ok && hit_thd) begin
        thd_assign_ff <= wr_data_in[`SSM_PRM_W-1:0];
      end
      if (wr_ok && hit_imsk) begin
        int_mask_ff <= wr_data_in[`SSM_INT_W-1:0];
      end
      int_stat_ff <= (int_stat_ff & ~w1c) | ev_set;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_ff <= '0;
    end else if (ce_in) begin
      rd_data_ff <= rd_in ? rd_mux : '0;
    end
  end

  // Output drive
  assign rd_data_out         = rd_data_ff;
  assign drive_enable_out    = drive_ff;
  assign monitor_pin_out     = stop_ff;
  assign circuit_health_flag = health_ff;
  assign display_code_out    = disp_ff;
  assign irq_out             = |(int_stat_ff & int_mask_ff);

  // Checks on the safety behaviour
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Drive off one cycle after a channel opens
  chk_open_stops_drive: assert property (
    (ce_in && !(a_stb && b_stb)) |=> !drive_enable_out
  ) else $error("drive stayed on with a channel open");

  // Release needs both shorted and no fault
  chk_drive_needs_short: assert property (
    (ce_in && both_short && !fault_any) |=> drive_enable_out
  ) else $error("drive not enabled on clean short");

  // Stop status on when dual open and healthy
  chk_stop_when_safe: assert property (
    (ce_in && both_open && !fault_any) |=> (monitor_pin_out && !drive_enable_out)
  ) else $error("stop status missing in safe stop");

  // Stop status off while faulted
  chk_stop_off_fault: assert property (
    (ce_in && fault_any) |=> (!monitor_pin_out && !circuit_health_flag)
  ) else $error("stop or health on during fault");

  // Health on whenever no fault is present
  chk_health_tracks: assert property (
    (ce_in && !fault_any) |=> circuit_health_flag
  ) else $error("health missing without fault");

  // Positive stop code on the second terminal
  chk_route_stop: assert property (
    (ce_in && sec_assign_ff == `SSM_FN_STOP_POS) |=> second_pin_out == $past(stop_ff)
  ) else $error("second terminal not carrying stop status");

  // Negative health code on the third terminal
  chk_route_health: assert property (
    (ce_in && thd_assign_ff == `SSM_FN_HEALTH_NEG) |=> third_pin_out == !$past(health_ff)
  ) else $error("third terminal not carrying inverted health");

  // Run terminal default carries running
  chk_run_default: assert property (
    (ce_in && run_assign_ff == `SSM_FN_RUNNING) |=> run_pin_out == $past(running_in)
  ) else $error("run terminal not showing running");

  // Run terminal off within two cycles of a fault
  chk_run_fault_off: assert property (
    (ce_in && fault_any && run_assign_ff == `SSM_FN_HEALTH_POS)
      ##1 (ce_in && run_assign_ff == `SSM_FN_HEALTH_POS) |=> !run_pin_out
  ) else $error("run terminal stayed on after fault");

  // Processor fault shows its own code
  chk_cpu_code: assert property (
    (ce_in && cpu_fault_in) |=> display_code_out == ssm_pkg::SSM_DISP_CPU
  ) else $error("processor fault code not shown");

  // Dual-open notice when healthy
  chk_dual_notice: assert property (
    (ce_in && both_open && !fault_any) |=> display_code_out == ssm_pkg::SSM_DISP_DUAL
  ) else $error("dual-open notice not shown");

  // Every event lands, a clear in the same cycle too
  chk_set_beats_clear: assert property (
    (ce_in && ev_set != '0) |=> (int_stat_ff & $past(ev_set)) == $past(ev_set)
  ) else $error("event lost under clear");

endmodule : ssm_top
`default_nettype wire
